// ### logic/mpi_addr_watch.sv
// buffer pointer watcher: near-overflow, fill warning and address match
// assumes pointer and address-list words are stable inputs on clk
`timescale 1ns/1ns
module mpi_addr_watch
  import mpi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] buf_ptr,
  input  wire logic [15:0] pkt_start_addr,
  input  wire logic [15:0] match_addr,
  input  wire logic [15:0] fill_words,
  output logic             ovf_near,
  output logic             fill_hit,
  output logic             match_hit
);
  logic [15:0] prev_ptr;
  logic        ptr_moved;
  logic [15:0] room;

  // fill and match events fire on pointer movement so a parked pointer fires once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_ptr <= ZERO16;
    end else begin
      prev_ptr <= buf_ptr;
    end
  end

  assign ptr_moved = (buf_ptr != prev_ptr);
  assign room      = mpi_room(pkt_start_addr, buf_ptr);
  assign ovf_near  = (room != ZERO16) && (room <= OVF_MARGIN);
  assign fill_hit  = ptr_moved && (room == fill_words);
  assign match_hit = ptr_moved && (buf_ptr == match_addr);
endmodule

// ### logic/mpi_event_if.sv
// carries the event vector from the packet logic to the interrupt registers
// assumes both ends share clk
`timescale 1ns/1ns
interface mpi_event_if;
  logic [15:0] events;
  modport src (output events);
  modport dst (input events);
endinterface

// ### logic/mpi_irq_regs.sv
// enable, pending and output-enable registers for the monitor events
// assumes events are one-cycle pulses and the read strobe is one cycle
`timescale 1ns/1ns
module mpi_irq_regs
  import mpi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  mpi_event_if.dst         ev,
  input  wire logic        wr_en,
  input  wire logic        wr_oe,
  input  wire logic        rd_pend,
  input  wire logic [15:0] wdata,
  output logic [15:0]      en,
  output logic [15:0]      oe,
  output logic [15:0]      pending,
  output logic             summary,
  output logic             irq_n
);
  logic [15:0] next_pending;
  logic [15:0] next_oe;

  // the pin follows an output enable written this cycle, not one later
  assign next_oe = wr_oe ? (wdata & IRQ_WMASK) : oe;

  // set wins over the read clear, so an event in that cycle survives
  genvar i;
  generate
    for (i = 0; i < DW; i++) begin : g_pend
      assign next_pending[i] = IRQ_WMASK[i] &&
        ((pending[i] && !rd_pend) || (ev.events[i] && en[i]));
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending <= ZERO16;
      irq_n   <= 1'b1;
      summary <= 1'b0;
    end else begin
      pending <= next_pending;
      summary <= |next_pending;
      irq_n   <= ~|(next_pending & next_oe);
    end
  end

  // low three bits are never stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en <= ZERO16;
      oe <= ZERO16;
    end else begin
      if (wr_en) en <= wdata & IRQ_WMASK;
      if (wr_oe) oe <= wdata & IRQ_WMASK;
    end
  end

  a_low_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (pending[2:0] == 3'h0) && (en[2:0] == 3'h0) && (oe[2:0] == 3'h0))
    else $error("low interrupt bits not zero");
  a_only_enabled: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((pending & ~$past(pending) & ~$past(ev.events & en))
              == ZERO16))
    else $error("pending bit set without enabled event");
  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
    rd_pend && ((ev.events & en) == ZERO16) |=> pending == ZERO16)
    else $error("pending not cleared by read");
  a_summary_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    summary == (pending != ZERO16))
    else $error("summary bit disagrees with pending");
  a_irq_pin: assert property (@(posedge clk) disable iff (!rst_n)
    irq_n == ((pending & oe) == ZERO16))
    else $error("interrupt pin disagrees with pending");
endmodule

// ### logic/mpi_pkg.sv
// constants, types and helpers for the packet-recording interrupt logic
// assumes one 25 MHz clock domain and a 16-bit host register port
package mpi_pkg;
  localparam int DW = 16;

  // register offsets on the host port
  localparam logic [15:0] ADDR_PEND     = 16'h0008;
  localparam logic [15:0] ADDR_EN       = 16'h0011;
  localparam logic [15:0] ADDR_OE       = 16'h0015;
  localparam logic [15:0] ADDR_MSG_LIM  = 16'h002a;
  localparam logic [15:0] ADDR_WRD_LIM  = 16'h002b;
  localparam logic [15:0] ADDR_TIME_LIM = 16'h002c;
  localparam logic [15:0] ADDR_GAP_LIM  = 16'h002d;

  // event bit positions
  localparam int BIT_OVF   = 15;
  localparam int BIT_WRD   = 14;
  localparam int BIT_MSG   = 13;
  localparam int BIT_GAP   = 12;
  localparam int BIT_TIME  = 11;
  localparam int BIT_STOP  = 10;
  localparam int BIT_DONE  = 9;
  localparam int BIT_MATCH = 6;
  localparam int BIT_FILL  = 5;

  localparam logic [15:0] IRQ_WMASK  = 16'hfff8;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam logic [15:0] ONE16      = 16'h0001;
  localparam logic [15:0] OVF_MARGIN = 16'h0040;

  typedef enum logic [1:0] {
    MPI_RUN       = 2'b00,
    MPI_STOP_WAIT = 2'b01,
    MPI_STOPPED   = 2'b10
  } mpi_rec_t;

  // words left before the pointer overwrites the packet start
  function automatic logic [15:0] mpi_room(input logic [15:0] start,
                                           input logic [15:0] ptr);
    mpi_room = start - ptr;
  endfunction
endpackage

// ### logic/mpi_top.sv
// packet-recording monitor: packet close reasons and interrupt events
// assumes the recorder pulses each word, each message end and time ticks
`timescale 1ns/1ns
module mpi_top
  import mpi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        rec_word,
  input  wire logic        rec_msg_end,
  input  wire logic        time_tick,
  input  wire logic        packet_stop_request,
  input  wire logic [15:0] buf_ptr,
  input  wire logic [15:0] pkt_start_addr,
  input  wire logic [15:0] match_addr,
  input  wire logic [15:0] fill_words,
  output logic             packet_close,
  output logic             recording,
  output logic [15:0]      event_vector,
  output logic             monitor_pending_summary,
  output logic             irq_n
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0] packet_message_count_limit;
  logic [15:0] packet_word_count_limit;
  logic [15:0] packet_time_limit;
  logic [15:0] packet_gap_time_limit;
  logic [15:0] en;
  logic [15:0] oe;
  logic [15:0] pending;
  logic [15:0] word_cnt;
  logic [15:0] msg_cnt;
  logic [15:0] time_cnt;
  logic [15:0] gap_cnt;
  logic        msg_active;
  logic        gap_fired;
  logic        ovf_hit;
  logic        wrd_hit;
  logic        time_hit;
  logic        ovf_now;
  logic        wrd_now;
  logic        time_now;
  logic        ovf_near;
  logic        fill_hit;
  logic        match_hit;
  logic        msg_hit_now;
  logic        close_now;
  logic        stop_close;
  logic        gap_fire;
  logic        running;
  logic        wr_en;
  logic        wr_oe;
  logic        rd_pend;
  logic [15:0] next_events;
  mpi_rec_t    state;
  mpi_rec_t    next_state;

  mpi_event_if evif ();

  ////////////////////////////////////////////////////////////////////////
  // host register port: writes decode, reads are registered
  assign wr_en   = reg_wr && (reg_addr == ADDR_EN);
  assign wr_oe   = reg_wr && (reg_addr == ADDR_OE);
  assign rd_pend = reg_rd && (reg_addr == ADDR_PEND);

  // limit registers, zero means the limit is not in use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      packet_message_count_limit <= ZERO16;
      packet_word_count_limit    <= ZERO16;
      packet_time_limit          <= ZERO16;
      packet_gap_time_limit      <= ZERO16;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MSG_LIM) begin
        packet_message_count_limit <= reg_wdata;
      end else if (reg_addr == ADDR_WRD_LIM) begin
        packet_word_count_limit <= reg_wdata;
      end else if (reg_addr == ADDR_TIME_LIM) begin
        packet_time_limit <= reg_wdata;
      end else if (reg_addr == ADDR_GAP_LIM) begin
        packet_gap_time_limit <= reg_wdata;
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= ZERO16;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_PEND) begin
        reg_rdata <= pending;
      end else if (reg_addr == ADDR_EN) begin
        reg_rdata <= en;
      end else if (reg_addr == ADDR_OE) begin
        reg_rdata <= oe;
      end else if (reg_addr == ADDR_MSG_LIM) begin
        reg_rdata <= packet_message_count_limit;
      end else if (reg_addr == ADDR_WRD_LIM) begin
        reg_rdata <= packet_word_count_limit;
      end else if (reg_addr == ADDR_TIME_LIM) begin
        reg_rdata <= packet_time_limit;
      end else if (reg_addr == ADDR_GAP_LIM) begin
        reg_rdata <= packet_gap_time_limit;
      end else begin
        reg_rdata <= ZERO16;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stop request state: finish the message, then stay stopped while the request is held
  always_comb begin
    next_state = state;
    case (state)
      MPI_RUN: begin
        if (packet_stop_request) next_state = MPI_STOP_WAIT;
      end
      MPI_STOP_WAIT: begin
        if (stop_close) next_state = MPI_STOPPED;
      end
      MPI_STOPPED: begin
        if (!packet_stop_request) next_state = MPI_RUN;
      end
      default: begin
        next_state = MPI_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= MPI_RUN;
    end else begin
      state <= next_state;
    end
  end

  assign running   = (state != MPI_STOPPED);
  assign recording = running;

  ////////////////////////////////////////////////////////////////////////
  // message tracking; a gap is any idle time between messages
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      msg_active <= 1'b0;
    end else if (rec_msg_end) begin
      msg_active <= 1'b0;
    end else if (rec_word) begin
      msg_active <= 1'b1;
    end
  end

  // close reasons; the message limit counts the message now ending, word and time limits what the packet already holds
  assign msg_hit_now = rec_msg_end && running &&
                       (packet_message_count_limit != ZERO16) &&
                       (msg_cnt + ONE16 == packet_message_count_limit);
  assign gap_fire    = running && !msg_active && !gap_fired &&
                       time_tick && (msg_cnt != ZERO16) &&
                       (packet_gap_time_limit != ZERO16) &&
                       (gap_cnt == packet_gap_time_limit);
  // an idle bus lets a time or stop close happen at once
  assign stop_close  = (state == MPI_STOP_WAIT) &&
                       (rec_msg_end || !msg_active);
  // a limit reached on the word just before message end still counts
  assign ovf_now  = ovf_hit || (ovf_near && (word_cnt != ZERO16));
  assign wrd_now  = wrd_hit || ((packet_word_count_limit != ZERO16) &&
                    (word_cnt >= packet_word_count_limit));
  assign time_now = time_hit || ((packet_time_limit != ZERO16) &&
                    (time_cnt >= packet_time_limit));
  assign close_now   = running &&
    ((rec_msg_end && (ovf_now || wrd_now || time_now)) ||
     msg_hit_now || gap_fire || stop_close ||
     (time_now && !msg_active));

  // per-packet counters restart at every close
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_cnt <= ZERO16;
      msg_cnt  <= ZERO16;
    end else if (close_now) begin
      word_cnt <= ZERO16;
      msg_cnt  <= ZERO16;
    end else if (running) begin
      if (rec_word) word_cnt <= word_cnt + ONE16;
      if (rec_msg_end) msg_cnt <= msg_cnt + ONE16;
    end
  end

  // packet time runs from the first recorded word of the packet
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      time_cnt <= ZERO16;
    end else if (close_now) begin
      time_cnt <= ZERO16;
    end else if (running && time_tick && (word_cnt != ZERO16)) begin
      time_cnt <= time_cnt + ONE16;
    end
  end

  // gap counter fires once per gap; it keeps counting after that and wraps on long idle gaps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_cnt   <= ZERO16;
      gap_fired <= 1'b0;
    end else if (msg_active || rec_word) begin
      gap_cnt   <= ZERO16;
      gap_fired <= 1'b0;
    end else begin
      if (time_tick) gap_cnt <= gap_cnt + ONE16;
      if (gap_fire) gap_fired <= 1'b1;
    end
  end

  // sticky close reasons wait for the end of the message
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_hit  <= 1'b0;
      wrd_hit  <= 1'b0;
      time_hit <= 1'b0;
    end else if (close_now) begin
      ovf_hit  <= 1'b0;
      wrd_hit  <= 1'b0;
      time_hit <= 1'b0;
    end else if (running) begin
      if (ovf_near && (word_cnt != ZERO16)) ovf_hit <= 1'b1;
      if ((packet_word_count_limit != ZERO16) &&
          (word_cnt >= packet_word_count_limit)) wrd_hit <= 1'b1;
      if ((packet_time_limit != ZERO16) &&
          (time_cnt >= packet_time_limit)) time_hit <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event vector; several reasons may close the same packet
  always_comb begin
    next_events            = ZERO16;
    next_events[BIT_OVF]   = close_now && ovf_now && rec_msg_end;
    next_events[BIT_WRD]   = close_now && wrd_now && rec_msg_end;
    next_events[BIT_MSG]   = msg_hit_now;
    next_events[BIT_GAP]   = gap_fire;
    next_events[BIT_TIME]  = close_now && time_now;
    next_events[BIT_STOP]  = stop_close;
    next_events[BIT_DONE]  = |next_events[BIT_OVF:BIT_STOP];
    next_events[BIT_MATCH] = match_hit;
    next_events[BIT_FILL]  = fill_hit;
  end

  assign evif.events = next_events;

  // outputs registered so they line up with the pending update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      packet_close <= 1'b0;
      event_vector <= ZERO16;
    end else begin
      packet_close <= close_now;
      event_vector <= next_events;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // submodules
  mpi_addr_watch u_watch (
    .clk            (clk),
    .rst_n          (rst_n),
    .buf_ptr        (buf_ptr),
    .pkt_start_addr (pkt_start_addr),
    .match_addr     (match_addr),
    .fill_words     (fill_words),
    .ovf_near       (ovf_near),
    .fill_hit       (fill_hit),
    .match_hit      (match_hit)
  );

  mpi_irq_regs u_irq (
    .clk     (clk),
    .rst_n   (rst_n),
    .ev      (evif.dst),
    .wr_en   (wr_en),
    .wr_oe   (wr_oe),
    .rd_pend (rd_pend),
    .wdata   (reg_wdata),
    .en      (en),
    .oe      (oe),
    .pending (pending),
    .summary (monitor_pending_summary),
    .irq_n   (irq_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_stop_close;
    stop_close ##1 (state == MPI_STOPPED);
  endsequence

  a_done_is_or: assert property (@(posedge clk) disable iff (!rst_n)
    event_vector[BIT_DONE] == (|event_vector[BIT_OVF:BIT_STOP]))
    else $error("done bit is not the or of close bits");
  a_ovf_closes: assert property (@(posedge clk) disable iff (!rst_n)
    next_events[BIT_OVF] |=> packet_close && !ovf_hit)
    else $error("overflow event without close");
  a_word_limit: assert property (@(posedge clk) disable iff (!rst_n)
    running && rec_msg_end && (packet_word_count_limit != ZERO16) &&
    (word_cnt >= packet_word_count_limit)
    |=> event_vector[BIT_WRD] && packet_close)
    else $error("word limit not flagged at message end");
  a_msg_limit: assert property (@(posedge clk) disable iff (!rst_n)
    rec_msg_end && running && (packet_message_count_limit != ZERO16) &&
    (msg_cnt == packet_message_count_limit - ONE16)
    |=> event_vector[BIT_MSG] && packet_close && (msg_cnt == ZERO16))
    else $error("message limit missed");
  a_gap_closes: assert property (@(posedge clk) disable iff (!rst_n)
    next_events[BIT_GAP] |-> !msg_active ##1 packet_close)
    else $error("gap event inside a message");
  a_time_waits: assert property (@(posedge clk) disable iff (!rst_n)
    next_events[BIT_TIME] |-> rec_msg_end || !msg_active)
    else $error("time close cut a message");
  a_stop_stops: assert property (@(posedge clk) disable iff (!rst_n)
    (state == MPI_STOP_WAIT) && stop_close |-> s_stop_close)
    else $error("stop did not end recording");
  a_match_event: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(buf_ptr) && (buf_ptr == match_addr)
    |=> event_vector[BIT_MATCH])
    else $error("address match not flagged");
endmodule

// ### tb/testbench.sv
// self-checking bench for the packet-recording interrupt block
// assumes mpi_top and mpi_pkg from logic/, one 25 MHz clock
`timescale 1ns/1ns
module testbench
  import mpi_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        reg_wr;
  logic        reg_rd;
  logic        rec_word;
  logic        rec_msg_end;
  logic        time_tick;
  logic        stop_req;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] buf_ptr;
  logic [15:0] start_addr;
  logic [15:0] match_addr;
  logic [15:0] fill_words;
  logic [15:0] reg_rdata;
  logic [15:0] event_vector;
  logic [15:0] seen;
  logic [15:0] lim;
  logic        packet_close;
  logic        recording;
  logic        summary;
  logic        irq_n;
  int          n_mismatch;
  int          n_tests;
  int          closes;
  int          seed;

  //////////////////////////////////////////////////////////////////////////
  mpi_top i_dut (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .rec_word                (rec_word),
    .rec_msg_end             (rec_msg_end),
    .time_tick               (time_tick),
    .packet_stop_request     (stop_req),
    .buf_ptr                 (buf_ptr),
    .pkt_start_addr          (start_addr),
    .match_addr              (match_addr),
    .fill_words              (fill_words),
    .packet_close            (packet_close),
    .recording               (recording),
    .event_vector            (event_vector),
    .monitor_pending_summary (summary),
    .irq_n                   (irq_n)
  );

  // free-running 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // event pulses last one cycle, so gather them for later comparison
  always @(posedge clk) begin
    if (!rst_n) begin
      seen   <= 16'h0000;
      closes <= 0;
    end else begin
      seen <= seen | event_vector;
      if (packet_close === 1'b1) closes <= closes + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // inputs move 1 ns after the edge, never on it
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // model of the event word: done bit follows any close reason
  function automatic logic [15:0] ev_model(input logic [15:0] term,
                                           input logic [15:0] other);
    ev_model = term | other | (((term & 16'hfc00) != 16'h0000) ?
                               16'h0200 : 16'h0000);
  endfunction

  task automatic do_reset();
    rst_n = 1'b0;
    {reg_wr, reg_rd, rec_word, rec_msg_end, time_tick, stop_req} = 6'h00;
    reg_addr   = 16'h0000;
    reg_wdata  = 16'h0000;
    buf_ptr    = 16'h0000;
    start_addr = 16'h1000;
    match_addr = 16'hffff;
    fill_words = 16'h0000;
    repeat (3) tick();
    rst_n = 1'b1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [15:0] a);
    reg_addr = a;
    reg_rd   = 1'b1;
    tick();
    reg_rd = 1'b0;
    tick();
  endtask

  task automatic msg(input int words);
    repeat (words) begin
      rec_word = 1'b1;
      tick();
    end
    rec_word    = 1'b0;
    rec_msg_end = 1'b1;
    tick();
    rec_msg_end = 1'b0;
    tick();
  endtask

  // bounded wait for a given number of closed packets
  task automatic wait_close(input int n);
    int k;
    k = 0;
    while (closes != n && k < 20) begin
      tick();
      k++;
    end
    if (closes != n) begin
      n_mismatch++;
      $display("mismatch packet_close expected %0d seen %0d", n, closes);
      end_of_test();
    end
  endtask

  // read pending, compare, then confirm it was cleared by the read
  task automatic chk_pend(input logic [15:0] e);
    rd(ADDR_PEND);
    chk("pending", e, reg_rdata);
    tick();
    chk("summary after read", 16'h0000, {15'h0, summary});
    chk("irq_n after read", 16'h0001, {15'h0, irq_n});
    rd(ADDR_PEND);
    chk("pending reread", 16'h0000, reg_rdata);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    n_tests    = 0;
    seed       = 50;
    do_reset();

    // register reset values, stuck low bits, unmapped place
    rd(ADDR_EN);
    chk("enable reset", 16'h0000, reg_rdata);
    wr(ADDR_EN, 16'hfe67);
    wr(ADDR_OE, 16'hffff);
    rd(ADDR_EN);
    chk("enable bits", 16'hfe60, reg_rdata);
    rd(ADDR_OE);
    chk("oe bits", 16'hfff8, reg_rdata);
    rd(ADDR_PEND);
    chk("pending reset", 16'h0000, reg_rdata);
    foreach (lim[i]) lim[i] = 1'b0;
    for (int a = 16'h002a; a <= 16'h002d; a++) begin
      lim = 16'($random(seed));
      wr(16'(a), lim);
      rd(16'(a));
      chk("limit readback", lim, reg_rdata);
    end
    wr(16'h0030, 16'h1234);
    rd(16'h0030);
    chk("unmapped read", 16'h0000, reg_rdata);
    $display("test registers done");

    // message limit, irq through output enable
    do_reset();
    lim = 16'(1 + ($random(seed) & 3));
    wr(ADDR_EN, 16'hfe60);
    wr(ADDR_OE, 16'h2000);
    wr(ADDR_MSG_LIM, lim);
    repeat (int'(lim) - 1) msg(1);
    chk("events before limit", 16'h0000, seen);
    msg(1);
    wait_close(1);
    tick();
    chk("msg limit events", ev_model(16'h2000, 16'h0), seen);
    chk("irq_n asserted", 16'h0000, {15'h0, irq_n});
    chk("summary set", 16'h0001, {15'h0, summary});
    chk_pend(ev_model(16'h2000, 16'h0));
    $display("test message limit done");

    // word limit across messages, polled only
    do_reset();
    lim = 16'(2 + ($random(seed) & 3));
    wr(ADDR_EN, 16'hfe60);
    wr(ADDR_WRD_LIM, lim);
    msg(int'(lim) - 1);
    chk("words below limit", 16'h0000, seen);
    msg(1);
    wait_close(1);
    tick();
    chk("word limit events", ev_model(16'h4000, 16'h0), seen);
    chk("irq_n polled", 16'h0001, {15'h0, irq_n});
    chk_pend(ev_model(16'h4000, 16'h0));
    $display("test word limit done");

    // disabled event is never remembered
    do_reset();
    wr(ADDR_MSG_LIM, 16'h0001);
    msg(1);
    wait_close(1);
    wr(ADDR_EN, 16'hfe60);
    tick();
    chk("late enable", 16'h0000, {15'h0, summary});
    chk_pend(16'h0000);
    $display("test disabled event done");

    // host stop in mid message
    do_reset();
    wr(ADDR_EN, 16'hfe60);
    wr(ADDR_OE, 16'hffff);
    rec_word = 1'b1;
    tick();
    rec_word = 1'b0;
    stop_req = 1'b1;
    repeat (3) tick();
    chk("no early stop", 16'h0000, 16'(closes));
    msg(0);
    wait_close(1);
    tick();
    chk("stopped", 16'h0000, {15'h0, recording});
    chk("stop events", ev_model(16'h0400, 16'h0), seen);
    stop_req = 1'b0;
    repeat (2) tick();
    chk("restarted", 16'h0001, {15'h0, recording});
    chk_pend(ev_model(16'h0400, 16'h0));
    $display("test host stop done");

    // gap limit counted in ticks while the bus is idle
    do_reset();
    lim = 16'(2 + ($random(seed) & 3));
    wr(ADDR_EN, 16'hfe60);
    wr(ADDR_GAP_LIM, lim);
    msg(2);
    time_tick = 1'b1;
    repeat (int'(lim) - 1) tick();
    time_tick = 1'b0;
    tick();
    chk("gap not exceeded", 16'h0000, seen);
    time_tick = 1'b1;
    repeat (3) tick();
    time_tick = 1'b0;
    wait_close(1);
    tick();
    chk("gap events", ev_model(16'h1000, 16'h0), seen);
    chk_pend(ev_model(16'h1000, 16'h0));
    $display("test gap limit done");

    // record time limit waits for the open message
    do_reset();
    lim = 16'(2 + ($random(seed) & 3));
    wr(ADDR_EN, 16'hfe60);
    wr(ADDR_TIME_LIM, lim);
    rec_word = 1'b1;
    tick();
    rec_word  = 1'b0;
    time_tick = 1'b1;
    repeat (int'(lim) + 2) tick();
    time_tick = 1'b0;
    tick();
    chk("time waits for message", 16'h0000, 16'(closes));
    msg(0);
    wait_close(1);
    tick();
    chk("time events", ev_model(16'h0800, 16'h0), seen);
    chk_pend(ev_model(16'h0800, 16'h0));
    $display("test time limit done");

    // pointer events: fill warning, address match, near overflow
    do_reset();
    start_addr = 16'h0100;
    fill_words = 16'h0080;
    match_addr = 16'h00c0;
    wr(ADDR_EN, 16'hfe60);
    buf_ptr = 16'h0080;
    repeat (2) tick();
    chk("fill warning", 16'h0020, seen);
    buf_ptr = 16'h00c0;
    repeat (2) tick();
    chk("address match", 16'h0060, seen);
    msg(1);
    wait_close(1);
    tick();
    chk("overflow events", ev_model(16'h8000, 16'h0060), seen);
    chk_pend(ev_model(16'h8000, 16'h0060));
    $display("test pointer events done");

    end_of_test();
  end
endmodule
